// ### rtl/core_clock_reset_control.sv
// Start-up clock source, ratio, lock wait and shared clock/reset pin control
//
// What this block does
// - Core clock comes from PLL or straight from input, chosen by the straps.
// - Start-up core ratio is taken from the straps as reset is left.
// - Once the core runs, software may rewrite PLL multiplier and divider.
// - Shared pin carries core reset by default; PLL control bit 12 selects PLL clock.
// - After reset release wait 4096 input cycles for lock, then start the core.
// - Straps decode 00 to 6:1, 01 to 32:1, 10 to 16:1.
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module core_clock_reset_control
  import clk_rst_pkg::*;
(
  // Input clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Strap pins
  input wire logic [1:0] ratio_select_straps,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Core side
  output logic core_reset_out,
  output logic core_clk_en,
  output logic [MULT_W-1:0] core_ratio,
  // Shared pin
  output logic clock_or_reset_output
);

  boot_state_t state_r;
  logic [LOCK_CNT_W-1:0] lock_cnt_r;
  logic [1:0] strap_r;
  logic bypass;
  logic core_run;
  pwr_mgmt_t pwr_mgmt_r;
  logic [31:0] pllctl_r;
  logic pll_sel;
  logic wr_pend_r;
  logic [7:0] wr_ofs_r;
  logic addr_ok;
  logic pm_wr;
  logic div_tick;
  logic div_wave;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // Straps and lock wait

  // Straps are sampled on every reset cycle, so the last one before release wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_r <= ratio_select_straps;
    end
  end

  assign bypass = (strap_r == STRAP_BYPASS);

  // Counter restarts from zero and state from ST_LOCK on any reset cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ST_LOCK;
      lock_cnt_r <= LOCK_ZERO;
    end else begin
      case (state_r)
        ST_LOCK: begin
          if (lock_cnt_r == LOCK_LAST) begin
            state_r <= ST_RUN;
          end else begin
            lock_cnt_r <= lock_cnt_r + LOCK_CNT_W'(1);
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_LOCK;
          lock_cnt_r <= LOCK_ZERO;
        end
      endcase
    end
  end

  assign core_run = (state_r == ST_RUN);
  assign core_reset_out = ~core_run;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
  assign pm_wr = wr_pend_r && (wr_ofs_r == PWR_MGMT_OFS);
  assign pll_sel = pllctl_r[PLL_SEL_BIT];

  assign status_word = {28'h0000000, bypass, strap_r, core_run};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_ofs_r <= haddr[7:0];
    end
  end

  // Read data is fetched in the address phase; unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        PWR_MGMT_OFS: hrdata <= {22'h000000, pwr_mgmt_r};
        PLLCTL_OFS: hrdata <= pllctl_r;
        STATUS_OFS: hrdata <= status_word;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Ratio writes before the core runs are dropped: the strap ratio must hold
  // through the lock wait, or the core would start at an unlocked rate
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwr_mgmt_r.mult <= ratio_of(ratio_select_straps);
      pwr_mgmt_r.div <= DIV_RESET;
    end else if (pm_wr && core_run) begin
      pwr_mgmt_r <= hwdata[DIV_LSB+DIV_W-1:MULT_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pllctl_r <= 32'h00000000;
    end else if (wr_pend_r && wr_ofs_r == PLLCTL_OFS) begin
      pllctl_r <= hwdata & (32'h00000001 << PLL_SEL_BIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core clock enable and shared pin

  pll_rate_divider u_div (
    .core_clk(core_clk),
    .reset(reset),
    .div(pwr_mgmt_r.div),
    .tick(div_tick),
    .wave(div_wave)
  );

  // Bypass runs the core at the input rate, ignoring the PLL settings
  assign core_clk_en = bypass ? 1'b1 : div_tick;
  assign core_ratio = bypass ? RATIO_1 : pwr_mgmt_r.mult;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      clock_or_reset_output <= 1'b1;
    end else begin
      clock_or_reset_output <= pll_sel ? div_wave : core_reset_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  lock_restart_a: assert property (
    $fell(reset) |-> state_r == ST_LOCK && lock_cnt_r == LOCK_ZERO && core_reset_out)
    else $error("lock wait did not restart after reset");

  lock_done_a: assert property (
    state_r == ST_LOCK && lock_cnt_r == LOCK_LAST |=> core_run && !core_reset_out)
    else $error("core did not start when lock wait ended");

  lock_early_a: assert property (
    core_run |-> lock_cnt_r == LOCK_LAST)
    else $error("core started before the full lock wait");

  strap_decode_a: assert property (
    $fell(reset) |-> pwr_mgmt_r.mult == ratio_of(strap_r))
    else $error("strap ratio decoded wrongly");

  strap_hold_a: assert property (
    !$past(reset) |-> $stable(strap_r))
    else $error("strap capture changed outside reset");

  bypass_run_a: assert property (
    bypass |-> core_clk_en [*4])
    else $error("bypass did not clock the core every cycle");

  ratio_write_a: assert property (
    pm_wr && core_run |=> pwr_mgmt_r == $past(hwdata[DIV_LSB+DIV_W-1:MULT_LSB]))
    else $error("ratio write while running not taken");

  ratio_locked_a: assert property (
    !core_run |=> $stable(pwr_mgmt_r))
    else $error("ratio changed during lock wait");

  pin_reset_a: assert property (
    !pll_sel |=> clock_or_reset_output == $past(core_reset_out))
    else $error("shared pin does not carry core reset");

  pin_clock_a: assert property (
    pll_sel |=> clock_or_reset_output == $past(div_wave))
    else $error("shared pin does not carry PLL clock");

  run_reached_c: cover property ($rose(core_run));
  ratio_write_c: cover property (pm_wr && core_run);
  pin_switch_c: cover property ($rose(pll_sel) ##[1:20] $changed(clock_or_reset_output));

endmodule : core_clock_reset_control

// ### inc/clk_rst_pkg.sv
// Constants, field layouts and types for the core clock and reset control block
package clk_rst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on the AHB-Lite slave)
  localparam logic [7:0] PWR_MGMT_OFS = 8'h00;
  localparam logic [7:0] PLLCTL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam int HTRANS_ACTIVE_BIT = 1;

  // Power management control fields
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 6;
  localparam int DIV_LSB = 6;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h1;

  // PLL control: selects what the shared output pin carries
  localparam int PLL_SEL_BIT = 12;

  // Status fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_STRAP_LSB = 1;
  localparam int STAT_BYPASS_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Strap codes and the ratios they select
  localparam logic [1:0] STRAP_R6 = 2'h0;
  localparam logic [1:0] STRAP_R32 = 2'h1;
  localparam logic [1:0] STRAP_R16 = 2'h2;
  localparam logic [1:0] STRAP_BYPASS = 2'h3;
  localparam logic [MULT_W-1:0] RATIO_6 = 6'h06;
  localparam logic [MULT_W-1:0] RATIO_32 = 6'h20;
  localparam logic [MULT_W-1:0] RATIO_16 = 6'h10;
  localparam logic [MULT_W-1:0] RATIO_1 = 6'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Lock wait, counted in input-clock cycles
  localparam int LOCK_CYCLES = 4096;
  localparam int LOCK_CNT_W = 12;
  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYCLES - 1);
  localparam logic [LOCK_CNT_W-1:0] LOCK_ZERO = 12'h000;

  typedef enum logic [1:0] {
    ST_LOCK = 2'b01,
    ST_RUN = 2'b10
  } boot_state_t;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [MULT_W-1:0] mult;
  } pwr_mgmt_t;

  function automatic logic [MULT_W-1:0] ratio_of(input logic [1:0] strap);
    logic [MULT_W-1:0] r;
    r = RATIO_1;
    case (strap)
      STRAP_R6: r = RATIO_6;
      STRAP_R32: r = RATIO_32;
      STRAP_R16: r = RATIO_16;
      default: r = RATIO_1;
    endcase
    return r;
  endfunction : ratio_of

endpackage : clk_rst_pkg

// ### rtl/pll_rate_divider.sv
// Enable-pulse divider standing in for the PLL output rate
`timescale 1ns/1ps
module pll_rate_divider
  import clk_rst_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Divide setting, zero behaves as one
  input wire logic [DIV_W-1:0] div,
  // Divided outputs
  output logic tick,
  output logic wave
);

  logic [DIV_W-1:0] cnt_r;
  logic wrap;

  assign wrap = (div == '0) || (cnt_r >= div - DIV_W'(1));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (wrap) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick <= 1'b0;
      wave <= 1'b0;
    end else begin
      tick <= wrap;
      if (wrap) begin
        wave <= ~wave;
      end
    end
  end

endmodule : pll_rate_divider

// ### tb/board_model.sv
// Board oscillator and reset source
`timescale 1ns/1ps
module board_model (
  // Reset request
  input wire logic rst_req,
  // Board outputs
  output logic core_clk,
  output logic reset
);
  // Free running, never halted or retuned
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Asserted from power-up until the request drops
  initial reset = 1'b1;
  always @(posedge core_clk) begin
    reset <= rst_req;
  end
endmodule : board_model

// ### tb/tb_core_clock_reset_control.sv
// Self-checking bench for the core clock and reset control block
`timescale 1ns/1ps
module tb_core_clock_reset_control;
  import clk_rst_pkg::*;
  logic core_clk, reset, rst_req, hsel, hwrite, hreadyout, hresp, bp, last_pin;
  logic core_reset_out, core_clk_en, clock_or_reset_output;
  logic [1:0] ratio_select_straps, htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, r, seed;
  logic [MULT_W-1:0] core_ratio;
  int fail_count, n_tests, cyc, rel, d, en_n, tg_n;

  board_model u_board (.rst_req(rst_req), .core_clk(core_clk), .reset(reset));
  core_clock_reset_control dut (.core_clk(core_clk), .reset(reset),
    .ratio_select_straps(ratio_select_straps), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .core_reset_out(core_reset_out), .core_clk_en(core_clk_en),
    .core_ratio(core_ratio), .clock_or_reset_output(clock_or_reset_output));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [5:0] exp_ratio(input logic [1:0] s);
    case (s)
      2'h0: return 6'h06;
      2'h1: return 6'h20;
      2'h2: return 6'h10;
      default: return 6'h01;
    endcase
  endfunction : exp_ratio

  task automatic complete_run();
    $display("Counts: %0d mismatches, %0d comparisons", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_pin(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t pin %b expected %b", $time, got, exp);
    end
  endtask : cmp_pin

  // Single transfer; read data taken at the data-phase edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
    cmp_pin(hresp, 1'b0);
  endtask : bus

  // Cuts a hang short; the four lock waits need about 17000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, ratio_select_straps} = '0;
    rst_req = 1'b1;
    seed = 32'h00000059;
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      ratio_select_straps <= s[1:0];
      rst_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      rst_req <= 1'b0;
      bp = (s == 3);
      #1;
      cmp_word(32'(core_ratio), 32'(exp_ratio(s[1:0])));
      cmp_pin(clock_or_reset_output, 1'b1);
      @(posedge core_clk);
      while (reset !== 1'b0) @(posedge core_clk);
      rel = cyc;
      // Straps move once reset is gone; the captured code must not follow them
      r = xs();
      ratio_select_straps <= r[1:0];
      // Written during the lock wait, so it must be dropped
      bus(PWR_MGMT_OFS, 1'b1, xs());
      // The release edge counts as the first of the wait: stop one edge before the end
      while (cyc != rel + LOCK_CYCLES - 2) @(posedge core_clk);
      #1;
      cmp_pin(core_reset_out, 1'b1);
      @(posedge core_clk);
      #1;
      cmp_pin(core_reset_out, 1'b0);
      bus(STATUS_OFS, 1'b0, 32'h0);
      cmp_word(rd, {28'h0, bp, s[1:0], 1'b1});
      bus(PWR_MGMT_OFS, 1'b0, 32'h0);
      cmp_word(rd, {22'h0, 4'h1, exp_ratio(s[1:0])});
      r = xs();
      bus(PWR_MGMT_OFS, 1'b1, r);
      bus(PWR_MGMT_OFS, 1'b0, 32'h0);
      cmp_word(rd, {22'h0, r[9:0]});
      cmp_word(32'(core_ratio), bp ? 32'h1 : 32'(r[5:0]));
      d = (r[9:6] == 4'h0) ? 1 : int'(r[9:6]);
      bus(PLLCTL_OFS, 1'b1, xs() | 32'h1000);
      bus(PLLCTL_OFS, 1'b0, 32'h0);
      cmp_word(rd, 32'h1000);
      // Divider compares against the new setting at once, so the period in progress may end early or run long
      repeat (20) @(posedge core_clk);
      en_n = 0;
      tg_n = 0;
      last_pin = clock_or_reset_output;
      repeat (4 * d) begin
        @(posedge core_clk);
        en_n += int'(core_clk_en === 1'b1);
        tg_n += int'(clock_or_reset_output !== last_pin);
        last_pin = clock_or_reset_output;
      end
      cmp_word(32'(en_n), bp ? 32'(4 * d) : 32'h4);
      cmp_word(32'(tg_n), 32'h4);
      bus(PLLCTL_OFS, 1'b1, 32'h0);
      repeat (2) @(posedge core_clk);
      #1;
      cmp_pin(clock_or_reset_output, 1'b0);
      $display("Test strap %0d done", s);
    end
    bus(8'h0C, 1'b0, 32'h0);
    cmp_word(rd, 32'h0);
    $display("Test unmapped read done");
    complete_run();
  end
endmodule : tb_core_clock_reset_control
